/* design/smrw_pkg.sv */
// Constants, register map and carrier types for the supply supervisor block.
// Assumes an APB master on pclk; the slow clock is pclk itself.
package smrw_pkg;
    localparam logic [7:0] ADDR_CR   = 8'h00;
    localparam logic [7:0] ADDR_SMMR = 8'h04;
    localparam logic [7:0] ADDR_MR   = 8'h08;
    localparam logic [7:0] ADDR_WUMR = 8'h0C;
    localparam logic [7:0] ADDR_WUIR = 8'h10;
    localparam logic [7:0] ADDR_SR   = 8'h14;
    localparam logic [7:0] CR_KEY    = 8'hA5;
    localparam int CR_KEY_POS   = 24;
    localparam int CR_REGULATOR_OFF_COMMAND_POS = 2;
    localparam int SMMR_SMPL_POS = 8;
    localparam int SMMR_RST_POS  = 12;
    localparam int SMMR_IEN_POS  = 13;
    localparam int MR_BODRST_POS = 12;
    localparam int MR_BUPPOR_POS = 14;
    localparam logic [31:0] MR_RESET = 32'h0000DA00;
    localparam int WUMR_FWEN_POS  = 0;
    localparam int WUMR_MONITOR_WAKEUP_ENABLE_POS  = 1;
    localparam int WUMR_FWDBC_POS = 8;
    localparam int WUMR_WKDBC_POS = 12;
    localparam int WUIR_TYPE_POS  = 16;
    localparam int SR_FWS_POS   = 0;
    localparam int SR_WKS_POS   = 1;
    localparam int SR_SMS_POS   = 2;
    localparam int SR_BODS_POS  = 3;
    localparam int SR_MONITOR_LIVE_OUTPUT_POS  = 5;
    localparam int SR_WKIS_POS  = 16;
    localparam logic [2:0] STARTUP_CYCLES = 3'h5;
    localparam logic [15:0] DBC_1 = 16'h0001;
    localparam logic [15:0] DBC_3 = 16'h0003;
    localparam logic [15:0] DBC_32 = 16'h0020;
    localparam logic [15:0] DBC_512 = 16'h0200;
    localparam logic [15:0] DBC_4096 = 16'h1000;
    localparam logic [15:0] DBC_32768 = 16'h8000;
    typedef enum logic [2:0] { SMRW_ST_START, SMRW_ST_REGON, SMRW_ST_RUN, SMRW_ST_BOD,
                               SMRW_ST_OFF1, SMRW_ST_OFF2, SMRW_ST_BACKUP } smrw_state_t;
    typedef struct packed {
        logic        rst_en;
        logic        irq_en;
        logic [2:0]  sampling;
        logic [3:0]  threshold;
    } smrw_smmr_t;
endpackage : smrw_pkg

/* design/smrw_top.sv */
// Supply supervisor: monitor sampling, reset sequencing, shutdown and wake-up debounce.
// Assumes pclk is the slow clock and all pins are synchronous except the monitor output.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module smrw_top #(
    parameter int WAKE_N = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              monitor_detect_raw,
    input  wire logic              core_voltage_status,
    input  wire logic              force_wake_pin,
    input  wire logic [WAKE_N-1:0] wake_input_pins,
    output logic                   monitor_enable,
    output logic [3:0]             monitor_threshold_field,
    output logic                   regulator_shutdown_output,
    output logic                   regulator_enable,
    output logic                   system_reset_n,
    output logic                   core_stop,
    output logic                   backup_por_enable,
    output logic                   monitor_irq
);
    // ******************************************************************
    // Register bus
    // ******************************************************************
    smrw_pkg::smrw_smmr_t smmr_reg;
    logic [31:0]          mr_reg;
    logic [31:0]          wumr_reg;
    logic [31:0]          wuir_reg;
    logic                 fws_reg;
    logic                 wks_reg;
    logic                 sms_reg;
    logic                 bods_reg;
    logic                 monitor_live_output_reg;
    logic [WAKE_N-1:0]    wkis_reg;
    logic [31:0]          prdata_reg;
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire rd      = acc & ~pwrite;
    wire hit_cr   = paddr == smrw_pkg::ADDR_CR;
    wire hit_smmr = paddr == smrw_pkg::ADDR_SMMR;
    wire hit_mr   = paddr == smrw_pkg::ADDR_MR;
    wire hit_wumr = paddr == smrw_pkg::ADDR_WUMR;
    wire hit_wuir = paddr == smrw_pkg::ADDR_WUIR;
    wire hit_sr   = paddr == smrw_pkg::ADDR_SR;
    wire mapped   = hit_cr | hit_smmr | hit_mr | hit_wumr | hit_wuir | hit_sr;
    wire sr_read  = rd & hit_sr;
    wire regulator_off_command_cmd = wr & hit_cr & pwdata[smrw_pkg::CR_REGULATOR_OFF_COMMAND_POS]
                   & (pwdata[smrw_pkg::CR_KEY_POS +: 8] == smrw_pkg::CR_KEY);
    wire [15:0] wkis_word = 16'(wkis_reg);
    wire [31:0] sr_word = {wkis_word, 10'h000, monitor_live_output_reg, 1'b0,
                           bods_reg, sms_reg, wks_reg, fws_reg};
    wire [31:0] rd_mux = hit_smmr ? {18'h00000, smmr_reg.irq_en, smmr_reg.rst_en, 1'b0,
                                     smmr_reg.sampling, 4'h0, smmr_reg.threshold} :
                         hit_mr   ? mr_reg :
                         hit_wumr ? wumr_reg :
                         hit_wuir ? wuir_reg :
                         hit_sr   ? sr_word : 32'h00000000;
    // Read data is captured in the setup cycle so that it already stands at the access edge.
    wire        rd_setup    = psel & ~penable & ~pwrite;
    wire [31:0] prdata_next = rd_setup ? rd_mux : (psel ? prdata_reg : 32'h00000000);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smmr_reg <= '0;
            mr_reg   <= smrw_pkg::MR_RESET;
            wumr_reg <= 32'h00000000;
            wuir_reg <= 32'h00000000;
        end
        else if (wr)
        begin
            if (hit_smmr)
                smmr_reg <= {pwdata[smrw_pkg::SMMR_RST_POS], pwdata[smrw_pkg::SMMR_IEN_POS],
                             pwdata[smrw_pkg::SMMR_SMPL_POS +: 3], pwdata[3:0]};
            if (hit_mr)
                mr_reg <= pwdata;
            if (hit_wumr)
                wumr_reg <= pwdata;
            if (hit_wuir)
                wuir_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h00000000;
        else
            prdata_reg <= prdata_next;
    end

    // ******************************************************************
    // Supply monitor sampling
    // ******************************************************************
    logic        mon_s1_reg;
    logic        mon_s2_reg;
    logic [10:0] smpl_cnt_reg;
    wire [10:0] smpl_last = smmr_reg.sampling == 3'h2 ? 11'h01F :
                            smmr_reg.sampling == 3'h3 ? 11'h0FF : 11'h7FF;
    wire continuous = smmr_reg.sampling == 3'h1;
    wire mon_off    = smmr_reg.sampling == 3'h0;
    wire sampled    = smmr_reg.sampling > 3'h1 && smmr_reg.sampling < 3'h5;
    wire mon_on     = continuous | (sampled & (smpl_cnt_reg == 11'h000));
    logic mon_on_d_reg;
    wire mon_detect = mon_on_d_reg & mon_s2_reg;
    assign monitor_enable          = mon_on & ~mon_off;
    assign monitor_threshold_field = smmr_reg.threshold;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mon_s1_reg   <= 1'b0;
            mon_s2_reg   <= 1'b0;
            smpl_cnt_reg <= 11'h000;
            mon_on_d_reg <= 1'b0;
            monitor_live_output_reg     <= 1'b0;
        end
        else
        begin
            mon_s1_reg   <= monitor_detect_raw;
            mon_s2_reg   <= mon_s1_reg;
            mon_on_d_reg <= mon_on;
            smpl_cnt_reg <= (!sampled || smpl_cnt_reg == smpl_last) ? 11'h000 : smpl_cnt_reg + 11'h001;
            if (mon_off)
                monitor_live_output_reg <= 1'b0;
            else if (mon_on_d_reg)
                monitor_live_output_reg <= mon_s2_reg;
        end
    end

    // ******************************************************************
    // Wake-up debounce
    // ******************************************************************
    logic [15:0] fw_cnt_reg;
    logic [15:0] wk_cnt_reg;
    wire [WAKE_N-1:0] wk_en  = wuir_reg[WAKE_N-1:0];
    wire [WAKE_N-1:0] wk_pol = wuir_reg[smrw_pkg::WUIR_TYPE_POS +: WAKE_N];
    wire [WAKE_N-1:0] wk_act = wk_en & ~(wake_input_pins ^ wk_pol);
    wire wk_any = |wk_act;
    wire fw_act = wumr_reg[smrw_pkg::WUMR_FWEN_POS] & ~force_wake_pin;

    function automatic logic [15:0] dbc_len(input logic [2:0] code);
        case (code)
            3'h0:    dbc_len = smrw_pkg::DBC_1;
            3'h1:    dbc_len = smrw_pkg::DBC_3;
            3'h2:    dbc_len = smrw_pkg::DBC_32;
            3'h3:    dbc_len = smrw_pkg::DBC_512;
            3'h4:    dbc_len = smrw_pkg::DBC_4096;
            default: dbc_len = smrw_pkg::DBC_32768;
        endcase
    endfunction : dbc_len

    wire [15:0] fw_len = dbc_len(wumr_reg[smrw_pkg::WUMR_FWDBC_POS +: 3]);
    wire [15:0] wk_len = dbc_len(wumr_reg[smrw_pkg::WUMR_WKDBC_POS +: 3]);
    wire fw_done = fw_act & (fw_cnt_reg + 16'h0001 >= fw_len);
    wire wk_done = wk_any & (wk_cnt_reg + 16'h0001 >= wk_len);
    wire sm_wake = mon_detect & wumr_reg[smrw_pkg::WUMR_MONITOR_WAKEUP_ENABLE_POS];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fw_cnt_reg <= 16'h0000;
            wk_cnt_reg <= 16'h0000;
        end
        else
        begin
            fw_cnt_reg <= (fw_act && !fw_done) ? fw_cnt_reg + 16'h0001 : 16'h0000;
            wk_cnt_reg <= (wk_any && !wk_done) ? wk_cnt_reg + 16'h0001 : 16'h0000;
        end
    end

    // ******************************************************************
    // Power sequencer
    // ******************************************************************
    smrw_pkg::smrw_state_t state_reg;
    smrw_pkg::smrw_state_t state_next;
    logic [2:0] start_cnt_reg;
    logic       core_ok_reg;
    logic       core_lost_reg;
    logic       in_backup;
    wire bod_en  = mr_reg[smrw_pkg::MR_BODRST_POS];
    wire bod_hit = bod_en & core_lost_reg & ~core_voltage_status;
    wire sm_rst  = mon_detect & smmr_reg.rst_en;
    wire wake    = fw_done | wk_done | sm_wake;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            smrw_pkg::SMRW_ST_START:
                if (start_cnt_reg == smrw_pkg::STARTUP_CYCLES - 3'h1)
                    state_next = smrw_pkg::SMRW_ST_REGON;
            smrw_pkg::SMRW_ST_REGON:
                if (core_ok_reg && core_voltage_status)
                    state_next = smrw_pkg::SMRW_ST_RUN;
            smrw_pkg::SMRW_ST_RUN:
                if (regulator_off_command_cmd)
                    state_next = smrw_pkg::SMRW_ST_OFF1;
                else if (bod_hit)
                    state_next = smrw_pkg::SMRW_ST_BOD;
            smrw_pkg::SMRW_ST_BOD:
                if (core_voltage_status)
                    state_next = smrw_pkg::SMRW_ST_RUN;
            smrw_pkg::SMRW_ST_OFF1:
                state_next = smrw_pkg::SMRW_ST_OFF2;
            smrw_pkg::SMRW_ST_OFF2:
                state_next = smrw_pkg::SMRW_ST_BACKUP;
            smrw_pkg::SMRW_ST_BACKUP:
                if (wake)
                    state_next = smrw_pkg::SMRW_ST_REGON;
            default:
                state_next = smrw_pkg::SMRW_ST_START;
        endcase
    end

    assign in_backup = state_reg == smrw_pkg::SMRW_ST_BACKUP;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg     <= smrw_pkg::SMRW_ST_START;
            start_cnt_reg <= 3'h0;
            core_ok_reg   <= 1'b0;
            core_lost_reg <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            start_cnt_reg <= (state_reg == smrw_pkg::SMRW_ST_START) ? start_cnt_reg + 3'h1 : 3'h0;
            core_ok_reg   <= core_voltage_status;
            core_lost_reg <= ~core_voltage_status & regulator_enable;
        end
    end

    // Outputs come from state_next decode, and reset is also held by sm_rst; state_next also decodes raw inputs such as core_voltage_status.
    logic rst_n_reg;
    logic regulator_shutdown_output_reg;
    logic stop_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_n_reg <= 1'b0;
            regulator_shutdown_output_reg  <= 1'b0;
            stop_reg  <= 1'b1;
        end
        else
        begin
            rst_n_reg <= state_next == smrw_pkg::SMRW_ST_RUN && !sm_rst;
            regulator_shutdown_output_reg  <= state_next == smrw_pkg::SMRW_ST_REGON || state_next == smrw_pkg::SMRW_ST_RUN
                      || state_next == smrw_pkg::SMRW_ST_BOD || state_next == smrw_pkg::SMRW_ST_OFF1;
            stop_reg  <= state_next != smrw_pkg::SMRW_ST_RUN;
        end
    end
    assign system_reset_n            = rst_n_reg;
    assign regulator_shutdown_output = regulator_shutdown_output_reg;
    assign regulator_enable          = regulator_shutdown_output_reg;
    assign core_stop                 = stop_reg;
    assign backup_por_enable         = mr_reg[smrw_pkg::MR_BUPPOR_POS];
    assign monitor_irq               = sms_reg & smmr_reg.irq_en;

    // ******************************************************************
    // Status flags: a set in the read cycle wins over the clear.
    // ******************************************************************
    // Only bits that the read returned are cleared, so an event between setup and access is kept.
    wire              sms_clr  = sr_read & prdata_reg[smrw_pkg::SR_SMS_POS];
    wire              fws_clr  = sr_read & prdata_reg[smrw_pkg::SR_FWS_POS];
    wire              wks_clr  = sr_read & prdata_reg[smrw_pkg::SR_WKS_POS];
    wire [WAKE_N-1:0] wkis_clr = sr_read ? prdata_reg[smrw_pkg::SR_WKIS_POS +: WAKE_N] : '0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fws_reg  <= 1'b0;
            wks_reg  <= 1'b0;
            sms_reg  <= 1'b0;
            bods_reg <= 1'b0;
            wkis_reg <= '0;
        end
        else
        begin
            sms_reg  <= mon_detect | (sms_reg & ~sms_clr);
            fws_reg  <= fw_done | (fws_reg & ~fws_clr);
            wks_reg  <= wk_done | (wks_reg & ~wks_clr);
            if (wk_done)
                wkis_reg <= wk_act;
            else
                wkis_reg <= wkis_reg & ~wkis_clr;
            if (state_reg == smrw_pkg::SMRW_ST_RUN && bod_hit)
                bods_reg <= 1'b1;
            else if (sm_rst || regulator_off_command_cmd)
                bods_reg <= 1'b0;
        end
    end
endmodule : smrw_top

/* tb/smrw_asserts.sv */
// Port checker for the supply supervisor top module.
// Assumes APB transfers are whole and pready answers every access.
`timescale 1ns/1ps
module smrw_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        core_voltage_status,
    input wire logic [3:0]  monitor_threshold_field,
    input wire logic        regulator_shutdown_output,
    input wire logic        regulator_enable,
    input wire logic        system_reset_n,
    input wire logic        core_stop,
    input wire logic        backup_por_enable
);
    // ****************************************
    // Assertions
    // ****************************************
    wire  wr_hit = psel && penable && pready && pwrite;
    wire  regulator_off_command  = wr_hit && paddr == smrw_pkg::ADDR_CR && pwdata[31:24] == smrw_pkg::CR_KEY && pwdata[2];
    logic bod_en_reg;
    // The brownout enable is shadowed here because it is not visible at the ports.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            bod_en_reg <= 1'b1;
        else if (wr_hit && paddr == smrw_pkg::ADDR_MR)
            bod_en_reg <= pwdata[smrw_pkg::MR_BODRST_POS];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_start; $rose(presetn) |-> !regulator_shutdown_output [*5] ##[1:2] regulator_shutdown_output; endproperty
    a_start: assert property (p_start) else $error("shutdown output start-up count wrong");
    property p_release; $rose(system_reset_n) |-> core_voltage_status && $past(core_voltage_status); endproperty
    a_release: assert property (p_release) else $error("reset released before core valid");
    property p_regulator_off_command; regulator_off_command |-> ##[1:2] !system_reset_n; endproperty
    a_regulator_off_command: assert property (p_regulator_off_command) else $error("reset late after regulator off");
    property p_sd_fall; $fell(regulator_shutdown_output) |-> !system_reset_n && $past(core_stop); endproperty
    a_sd_fall: assert property (p_sd_fall) else $error("shutdown fell before core stop");
    property p_bod; bod_en_reg && regulator_enable && !core_voltage_status ##1 regulator_enable && !core_voltage_status
        |-> ##[0:2] !system_reset_n; endproperty
    a_bod: assert property (p_bod) else $error("brownout reset missing");
    property p_bod_hold; !system_reset_n && regulator_enable && !core_voltage_status |=> !system_reset_n; endproperty
    a_bod_hold: assert property (p_bod_hold) else $error("reset released during powerfail");
    property p_por; wr_hit && paddr == smrw_pkg::ADDR_MR |=> backup_por_enable == $past(pwdata[14]); endproperty
    a_por: assert property (p_por) else $error("backup por enable not updated");
    property p_thr; wr_hit && paddr == smrw_pkg::ADDR_SMMR |=> monitor_threshold_field == $past(pwdata[3:0]);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold field not updated");
endmodule : smrw_asserts
bind smrw_top smrw_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .core_voltage_status(core_voltage_status),
    .monitor_threshold_field(monitor_threshold_field), .regulator_shutdown_output(regulator_shutdown_output),
    .regulator_enable(regulator_enable), .system_reset_n(system_reset_n), .core_stop(core_stop),
    .backup_por_enable(backup_por_enable));

/* tb/smrw_bench.sv */
// Self-checking bench for the supply supervisor.
// Assumes a 10 MHz pclk and the partner model on the core supply.
`timescale 1ns/1ps
module smrw_bench;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        det     = 1'b0;
    logic        fwp     = 1'b1;
    logic        fail    = 1'b0;
    logic [15:0] wkp     = 16'h0020;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, cvs, mon_en, sd, ren, rstn, cstop, por, irq;
    logic [3:0]  thr;
    int          n_fail = 0;
    int          checks_done = 0;
    int          k, cnt;
    logic [7:0]  ra [7] = '{smrw_pkg::ADDR_SMMR, smrw_pkg::ADDR_MR, smrw_pkg::ADDR_WUMR, smrw_pkg::ADDR_WUIR,
                            smrw_pkg::ADDR_SR, smrw_pkg::ADDR_CR, 8'h18};
    always #50 pclk = ~pclk;
    smrw_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitor_detect_raw(det),
        .core_voltage_status(cvs), .force_wake_pin(fwp), .wake_input_pins(wkp), .monitor_enable(mon_en),
        .monitor_threshold_field(thr), .regulator_shutdown_output(sd), .regulator_enable(ren),
        .system_reset_n(rstn), .core_stop(cstop), .backup_por_enable(por), .monitor_irq(irq));
    smrw_partner u_part (.pclk(pclk), .regulator_enable(ren), .fail_req(fail), .core_voltage_status(cvs));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge pclk);
        end
    endtask : tick
    // Waits on system_reset_n (sel 0) or the shutdown output (sel 1).
    task automatic wait_on(input int sel, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && (sel == 0 ? rstn : sd) !== v; i++)
            tick(1);
        if (i == lim)
        begin
            chk("wait bound", 32'h1, 32'h0);
            results();
        end
    endtask : wait_on
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        // Read data and the error flag are taken at the same edge that samples pready high.
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            chk("pready bound", 32'h1, 32'h0);
            results();
        end
        // One more edge lets the bench see what the write has changed.
        @(posedge pclk);
    endtask : apb
    task automatic backup();
        apb(1'b1, smrw_pkg::ADDR_CR, 32'hA500_0004);
        wait_on(1, 1'b0, 8);
        chk("core stopped", cstop, 1'b1);
        chk("regulator off", ren, 1'b0);
    endtask : backup
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        tick(16);
        chk("shutdown in reset", sd, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        tick(4);
        chk("shutdown early", sd, 1'b0);
        wait_on(1, 1'b1, 3);
        wait_on(0, 1'b1, 20);
        $display("test startup done");
        for (k = 0; k < 7; k++)
        begin
            apb(1'b0, ra[k], 32'h0);
            chk("reset value", rd, k == 1 ? smrw_pkg::MR_RESET : 32'h0);
            chk("slave error", err, k == 6);
        end
        chk("por enable reset", por, 1'b1);
        apb(1'b1, smrw_pkg::ADDR_MR, 32'h0000_9A00);
        chk("por enable off", por, 1'b0);
        apb(1'b1, smrw_pkg::ADDR_MR, smrw_pkg::MR_RESET);
        apb(1'b1, smrw_pkg::ADDR_SMMR, 32'h0000_010F);
        chk("threshold", thr, 4'hF);
        chk("continuous", mon_en, 1'b1);
        apb(1'b1, smrw_pkg::ADDR_SMMR, 32'h0000_0203);
        cnt = 0;
        for (k = 0; k < 64; k++)
        begin
            tick(1);
            cnt += mon_en;
        end
        chk("sample count", cnt, 2);
        $display("test registers done");
        apb(1'b1, smrw_pkg::ADDR_SMMR, 32'h0000_2100);
        det <= 1'b1;
        tick(4);
        chk("irq raised", irq, 1'b1);
        det <= 1'b0;
        tick(4);
        apb(1'b0, smrw_pkg::ADDR_SR, 32'h0);
        chk("sticky kept", rd & 32'h24, 32'h04);
        apb(1'b0, smrw_pkg::ADDR_SR, 32'h0);
        chk("sticky cleared", rd & 32'h24, 32'h00);
        chk("irq cleared", irq, 1'b0);
        apb(1'b1, smrw_pkg::ADDR_SMMR, 32'h0000_1100);
        det <= 1'b1;
        wait_on(0, 1'b0, 5);
        det <= 1'b0;
        wait_on(0, 1'b1, 20);
        $display("test monitor done");
        apb(1'b1, smrw_pkg::ADDR_SMMR, 32'h0000_0100);
        fail <= 1'b1;
        wait_on(0, 1'b0, 4);
        tick(4);
        chk("brownout hold", rstn, 1'b0);
        fail <= 1'b0;
        wait_on(0, 1'b1, 10);
        apb(1'b0, smrw_pkg::ADDR_SR, 32'h0);
        chk("brownout status", rd[3], 1'b1);
        $display("test brownout done");
        apb(1'b1, smrw_pkg::ADDR_WUMR, 32'h0000_0101);
        apb(1'b1, smrw_pkg::ADDR_CR, 32'h0000_0004);
        tick(4);
        chk("keyless write", rstn, 1'b1);
        backup();
        fwp <= 1'b0;
        tick(2);
        fwp <= 1'b1;
        tick(8);
        chk("short pulse", sd, 1'b0);
        fwp <= 1'b0;
        wait_on(1, 1'b1, 10);
        fwp <= 1'b1;
        wait_on(0, 1'b1, 20);
        apb(1'b0, smrw_pkg::ADDR_SR, 32'h0);
        chk("force status", rd[0], 1'b1);
        $display("test force wake done");
        apb(1'b1, smrw_pkg::ADDR_WUMR, 32'h0000_0000);
        apb(1'b1, smrw_pkg::ADDR_WUIR, 32'h0008_0028);
        backup();
        wkp <= 16'h0000;
        wait_on(1, 1'b1, 10);
        wkp <= 16'h0020;
        wait_on(0, 1'b1, 20);
        apb(1'b0, smrw_pkg::ADDR_SR, 32'h0);
        chk("wake sources", rd & 32'hFFFF_0002, 32'h0020_0002);
        apb(1'b1, smrw_pkg::ADDR_WUMR, 32'h0000_0002);
        backup();
        det <= 1'b1;
        wait_on(1, 1'b1, 10);
        det <= 1'b0;
        wait_on(0, 1'b1, 20);
        $display("test wake inputs done");
        results();
    end
endmodule : smrw_bench

/* tb/smrw_partner.sv */
// Core regulator and brownout detector model.
// Assumes the bench raises fail_req to emulate a core powerfail.
`timescale 1ns/1ps
module smrw_partner (
    input  wire logic pclk,
    input  wire logic regulator_enable,
    input  wire logic fail_req,
    output logic      core_voltage_status
);
    // ****************************************
    // Core supply ramp
    // ****************************************
    logic [1:0] ramp_reg;
    // The core is only reported valid three cycles after the regulator turns on, never at once.
    always_ff @(posedge pclk)
        if (!regulator_enable)
            ramp_reg <= 2'h0;
        else if (ramp_reg != 2'h3)
            ramp_reg <= ramp_reg + 2'h1;
    assign core_voltage_status = ramp_reg == 2'h3 && !fail_req;
endmodule : smrw_partner
